/* common/seh_pkg.sv */
// Shared constants and carrier types for the SMART enable/status handler.
// Assumes a single 40 MHz clock domain and a plain byte-addressed register port.
package seh_pkg;
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned ADDR_W = 13;
	localparam int unsigned ATTR_MAX = 30;
	localparam int unsigned ATTR_BYTES = 12;

	// Subcommands taken from the feature byte
	localparam logic [7:0] SUB_READ_VALUES = 8'hd0;
	localparam logic [7:0] SUB_SAVE_VALUES = 8'hd3;
	localparam logic [7:0] SUB_ENABLE = 8'hd8;
	localparam logic [7:0] SUB_DISABLE = 8'hd9;
	localparam logic [7:0] SUB_RETURN_STATUS = 8'hda;

	// Return-status signatures
	localparam logic [7:0] SIG_GOOD_MID = 8'h4f;
	localparam logic [7:0] SIG_GOOD_HIGH = 8'hc2;
	localparam logic [7:0] SIG_FAIL_MID = 8'hf4;
	localparam logic [7:0] SIG_FAIL_HIGH = 8'h2c;

	// Attribute data structure layout (byte indices)
	localparam logic [15:0] STRUCT_REV = 16'h0005;
	localparam logic [9:0] STRUCT_LEN = 10'h200;
	localparam logic [9:0] IDX_ATTR_FIRST = 10'h002;
	localparam logic [9:0] IDX_ATTR_LAST = 10'h169;
	localparam logic [9:0] IDX_OFF_STAT = 10'h16a;
	localparam logic [9:0] IDX_SELFTEST = 10'h16b;
	localparam logic [9:0] IDX_OFF_TIME_LO = 10'h16c;
	localparam logic [9:0] IDX_OFF_TIME_HI = 10'h16d;
	localparam logic [9:0] IDX_VENDOR = 10'h16e;
	localparam logic [9:0] IDX_OFF_CAP = 10'h16f;
	localparam logic [9:0] IDX_SMART_CAP_LO = 10'h170;
	localparam logic [9:0] IDX_SMART_CAP_HI = 10'h171;
	localparam logic [9:0] IDX_ERRLOG_CAP = 10'h172;
	localparam logic [9:0] IDX_CHECKPOINT = 10'h173;
	localparam logic [9:0] IDX_SHORT_POLL = 10'h174;
	localparam logic [9:0] IDX_EXT_POLL = 10'h175;
	localparam logic [9:0] IDX_CHECKSUM = 10'h1ff;

	// Entry layout and status flag bits
	localparam int unsigned ENT_ID = 0;
	localparam int unsigned ENT_FLAGS_LO = 1;
	localparam int unsigned ENT_VALUE = 3;
	localparam int unsigned FLAG_PREFAIL = 0;
	localparam int unsigned FLAG_ONLINE = 1;
	localparam int unsigned FLAG_PERF = 2;
	localparam int unsigned FLAG_ERR_RATE = 3;
	localparam int unsigned FLAG_EVENT_CNT = 4;
	localparam int unsigned FLAG_SELF_PRES = 5;

	// Register map (byte addresses)
	localparam logic [ADDR_W-1:0] REG_STATUS = 13'h0000;
	localparam logic [ADDR_W-1:0] REG_OFF_STAT = 13'h0004;
	localparam logic [ADDR_W-1:0] REG_SELFTEST = 13'h0008;
	localparam logic [ADDR_W-1:0] REG_OFF_TIME = 13'h000c;
	localparam logic [ADDR_W-1:0] REG_CAPS = 13'h0010;
	localparam logic [ADDR_W-1:0] REG_POLL = 13'h0014;
	localparam logic [1:0] WIN_ATTR = 2'h1;
	localparam logic [1:0] WIN_THRESH = 2'h2;

	localparam logic [1:0] NV_SETTLE = 2'h2;

	typedef struct packed {
		logic valid;
		logic [7:0] feature;
		logic [7:0] count;
	} seh_cmd_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [31:0] wdata;
		logic we;
		logic re;
	} seh_bus_t;

	typedef struct packed {
		logic bsy;
		logic drq;
		logic intrq;
		logic err;
		logic abrt;
		logic [7:0] lba_mid;
		logic [7:0] lba_high;
	} seh_tf_t;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_EXEC = 5'b00010,
		ST_CMP = 5'b00100,
		ST_XFER = 5'b01000,
		ST_DONE = 5'b10000
	} seh_state_t;
endpackage

/* design/seh_smart_handler.sv */
// SMART enable/disable, return-status and attribute-structure handler.
// Assumes the host task-file logic shares clk; nv_state and pwr_save_evt are pins.
// Overview of operation
// R1 - Enable subcommand: busy, turn SMART on, drop busy, raise interrupt.
// R2 - No monitoring or saving of attribute values before SMART is enabled; code still takes power-mode saves and self-preserving writes.
// R3 - Enabled state is kept in nonvolatile storage across power cycles.
// R4 - Repeated enable while enabled leaves attribute values untouched.
// R5 - Disable subcommand: busy, turn SMART and autosave off, drop busy, interrupt.
// R6 - Power-mode saves continue while disabled; non self-preserving values stop updating.
// R7 - While disabled, every subcommand except enable aborts with error.
// R8 - Values kept in sectors on disable; refreshed on read or save after enable.
// R9 - Return status: busy, save updated values, compare each value to threshold.
// R10 - No pre-failure exceedance: load 4Fh mid, C2h high, drop busy, interrupt.
// R11 - Pre-failure exceedance: load F4h mid, 2Ch high, drop busy, interrupt.
// R12 - 512-byte structure: revision, thirty entries, offline, self-test, checksum bytes.
// R13 - Whole structure goes out in one read-values transfer.
// R14 - Offline time, offline capability, SMART capability fields; 374-510 reserved zero.
// R15 - Byte 370 bit 0 error logging supported; byte 371 self-test checkpoint.
// R16 - Bytes 372 and 373 give short and extended self-test polling minutes.
// R17 - Revision field reads 0005h.
// R18 - Each entry is 12 bytes: id, then status flag word.
// R19 - Flag bit 0 marks pre-failure versus advisory attribute.
// R20 - Flag bit 1 marks online versus offline-only updating.
// R21 - Flag bits 2-5 mark performance, error-rate, event-count, self-preserving.
// R22 - Read values: busy, save, DRQ, drop busy, interrupt; host reads 512 bytes.
// R23 - Checksum makes the 8-bit sum of all 512 bytes zero.
module seh_smart_handler
	import seh_pkg::*;
#(
	parameter int unsigned ATTR_NUM = 30
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire seh_pkg::seh_cmd_t cmd,
	input wire logic intrq_ack,
	input wire logic data_rd,
	output logic [7:0] data_out,
	output seh_pkg::seh_tf_t tf,
	input wire seh_pkg::seh_bus_t bus,
	output logic [31:0] rdata,
	input wire logic nv_state,
	output logic nv_wr,
	output logic nv_wr_val,
	input wire logic pwr_save_evt,
	output logic smart_on
);
	import seh_pkg::*;

	if (ATTR_NUM < 1 || ATTR_NUM > ATTR_MAX) begin : g_chk
		$error("ATTR_NUM must lie between 1 and 30");
	end

	// Live values are what monitoring updates; saved values are the sector image
	logic [7:0] live_mem [0:ATTR_MAX-1][0:ATTR_BYTES-1];
	logic [7:0] sav_mem [0:ATTR_MAX-1][0:ATTR_BYTES-1];
	logic [7:0] thr_mem [0:ATTR_MAX-1];

	seh_state_t state_reg;
	seh_tf_t tf_reg;
	logic smart_en_reg;
	logic nv_s1_reg, nv_s2_reg, pw_s1_reg, pw_s2_reg, pw_s3_reg;
	logic [1:0] init_cnt_reg;
	logic loaded_reg;
	logic nv_wr_reg, nv_val_reg;
	logic [7:0] sub_reg;
	logic [4:0] cmp_idx_reg;
	logic fail_reg;
	logic [9:0] x_idx_reg;
	logic [4:0] x_ent_reg;
	logic [3:0] x_byte_reg;
	logic [7:0] x_sum_reg;
	logic [7:0] data_reg;
	logic [31:0] rdata_reg;
	logic [7:0] off_stat_reg, selftest_reg, off_cap_reg, checkpoint_reg, short_poll_reg, ext_poll_reg;
	logic [15:0] off_time_reg, smart_cap_reg;
	logic errlog_reg;

	logic cmd_take, save_now, pwr_evt, bus_attr, bus_thr;
	logic [4:0] b_ent;
	logic [3:0] b_byte;
	logic [7:0] x_byte;
	logic x_last;

	assign cmd_take = cmd.valid && state_reg == ST_IDLE && loaded_reg;
	assign pwr_evt = pw_s2_reg && !pw_s3_reg;
	// Saves on command only while enabled, power-mode saves always
	assign save_now = (state_reg == ST_EXEC && smart_en_reg && (sub_reg == SUB_READ_VALUES ||
		sub_reg == SUB_SAVE_VALUES || sub_reg == SUB_RETURN_STATUS)) || pwr_evt; // R2 R6 R8 R9 R22
	assign b_ent = bus.addr[10:6];
	assign b_byte = bus.addr[5:2];
	assign bus_attr = bus.addr[12:11] == WIN_ATTR && b_ent < 5'(ATTR_NUM) && b_byte < 4'(ATTR_BYTES);
	assign bus_thr = bus.addr[12:11] == 2'h0 && bus.addr[10] && bus.addr[9:7] == 3'h0 &&
		bus.addr[6:2] < 5'(ATTR_NUM);
	assign x_last = x_idx_reg == IDX_CHECKSUM;

	// Pin synchronisers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			nv_s1_reg <= 1'b0;
			nv_s2_reg <= 1'b0;
			pw_s1_reg <= 1'b0;
			pw_s2_reg <= 1'b0;
			pw_s3_reg <= 1'b0;
		end else if (ce) begin
			nv_s1_reg <= nv_state;
			nv_s2_reg <= nv_s1_reg;
			pw_s1_reg <= pwr_save_evt;
			pw_s2_reg <= pw_s1_reg;
			pw_s3_reg <= pw_s2_reg;
		end
	end

	// Enabled state restored from nonvolatile pin after reset, written back on every enable and on a disable while enabled
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			init_cnt_reg <= 2'h0;
			loaded_reg <= 1'b0;
			smart_en_reg <= 1'b0;
			nv_wr_reg <= 1'b0;
			nv_val_reg <= 1'b0;
		end else if (ce) begin
			nv_wr_reg <= 1'b0;
			if (!loaded_reg) begin
				if (init_cnt_reg == NV_SETTLE) begin
					smart_en_reg <= nv_s2_reg; // R3
					loaded_reg <= 1'b1;
				end else begin
					init_cnt_reg <= init_cnt_reg + 2'h1;
				end
			end else if (state_reg == ST_EXEC && sub_reg == SUB_ENABLE) begin
				smart_en_reg <= 1'b1; // R1 R4
				nv_wr_reg <= 1'b1; // R3
				nv_val_reg <= 1'b1;
			end else if (state_reg == ST_EXEC && sub_reg == SUB_DISABLE && smart_en_reg) begin
				smart_en_reg <= 1'b0; // R5
				nv_wr_reg <= 1'b1; // R3
				nv_val_reg <= 1'b0;
			end
		end
	end

	// Command sequencer
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_reg <= ST_IDLE;
			sub_reg <= 8'h00;
			cmp_idx_reg <= 5'h00;
			fail_reg <= 1'b0;
		end else if (ce) begin
			case (state_reg)
				ST_IDLE: begin
					if (cmd_take) begin
						sub_reg <= cmd.feature;
						state_reg <= ST_EXEC;
					end
				end
				ST_EXEC: begin
					cmp_idx_reg <= 5'h00;
					fail_reg <= 1'b0;
					if (!smart_en_reg && sub_reg != SUB_ENABLE)
						state_reg <= ST_DONE; // R7
					else if (sub_reg == SUB_RETURN_STATUS)
						state_reg <= ST_CMP; // R9
					else if (sub_reg == SUB_READ_VALUES)
						state_reg <= ST_XFER; // R13 R22
					else
						state_reg <= ST_DONE;
				end
				ST_CMP: begin
					// Advisory entries never fail; value at or below threshold counts
					if (sav_mem[cmp_idx_reg][ENT_ID] != 8'h00 &&
						sav_mem[cmp_idx_reg][ENT_FLAGS_LO][FLAG_PREFAIL] &&
						sav_mem[cmp_idx_reg][ENT_VALUE] <= thr_mem[cmp_idx_reg])
						fail_reg <= 1'b1; // R9 R19
					cmp_idx_reg <= cmp_idx_reg + 5'h01;
					if (cmp_idx_reg == 5'(ATTR_NUM - 1))
						state_reg <= ST_DONE;
				end
				ST_XFER: begin
					if (ce && data_rd && x_last)
						state_reg <= ST_IDLE; // R22
				end
				ST_DONE: state_reg <= ST_IDLE;
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// Task-file outputs; an interrupt raised in the ack cycle is kept
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tf_reg <= '0;
		end else if (ce) begin
			if (intrq_ack)
				tf_reg.intrq <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					if (cmd_take) begin
						tf_reg.bsy <= 1'b1; // R1 R5 R9 R22
						tf_reg.err <= 1'b0;
						tf_reg.abrt <= 1'b0;
						tf_reg.intrq <= 1'b0;
					end
				end
				ST_EXEC: begin
					if (!smart_en_reg && sub_reg != SUB_ENABLE) begin
						tf_reg.err <= 1'b1; // R7
						tf_reg.abrt <= 1'b1;
					end else if (sub_reg != SUB_RETURN_STATUS && sub_reg != SUB_READ_VALUES &&
						sub_reg != SUB_SAVE_VALUES && sub_reg != SUB_ENABLE && sub_reg != SUB_DISABLE) begin
						tf_reg.err <= 1'b1;
						tf_reg.abrt <= 1'b1;
					end
					if (smart_en_reg && sub_reg == SUB_READ_VALUES) begin
						tf_reg.drq <= 1'b1; // R22
						tf_reg.bsy <= 1'b0;
						tf_reg.intrq <= 1'b1;
					end
				end
				ST_CMP: begin
					if (cmp_idx_reg == 5'(ATTR_NUM - 1)) begin
						if (fail_reg || (sav_mem[cmp_idx_reg][ENT_ID] != 8'h00 &&
							sav_mem[cmp_idx_reg][ENT_FLAGS_LO][FLAG_PREFAIL] &&
							sav_mem[cmp_idx_reg][ENT_VALUE] <= thr_mem[cmp_idx_reg])) begin
							tf_reg.lba_mid <= SIG_FAIL_MID; // R11
							tf_reg.lba_high <= SIG_FAIL_HIGH;
						end else begin
							tf_reg.lba_mid <= SIG_GOOD_MID; // R10
							tf_reg.lba_high <= SIG_GOOD_HIGH;
						end
					end
				end
				ST_XFER: begin
					if (data_rd && x_last)
						tf_reg.drq <= 1'b0;
				end
				ST_DONE: begin
					tf_reg.bsy <= 1'b0; // R1 R5 R10 R11
					tf_reg.intrq <= 1'b1;
				end
				default: tf_reg.bsy <= 1'b0;
			endcase
		end
	end

	// Byte of the 512-byte structure at the current transfer index
	always_comb begin
		x_byte = 8'h00; // R14
		if (x_idx_reg == 10'h000)
			x_byte = STRUCT_REV[7:0]; // R17
		else if (x_idx_reg == 10'h001)
			x_byte = STRUCT_REV[15:8];
		else if (x_idx_reg <= IDX_ATTR_LAST)
			x_byte = x_ent_reg < 5'(ATTR_NUM) ? sav_mem[x_ent_reg][x_byte_reg] : 8'h00; // R12 R18
		else begin
			case (x_idx_reg)
				IDX_OFF_STAT: x_byte = off_stat_reg; // R12
				IDX_SELFTEST: x_byte = selftest_reg;
				IDX_OFF_TIME_LO: x_byte = off_time_reg[7:0]; // R14
				IDX_OFF_TIME_HI: x_byte = off_time_reg[15:8];
				IDX_OFF_CAP: x_byte = off_cap_reg;
				IDX_SMART_CAP_LO: x_byte = smart_cap_reg[7:0];
				IDX_SMART_CAP_HI: x_byte = smart_cap_reg[15:8];
				IDX_ERRLOG_CAP: x_byte = {7'h00, errlog_reg}; // R15
				IDX_CHECKPOINT: x_byte = checkpoint_reg;
				IDX_SHORT_POLL: x_byte = short_poll_reg; // R16
				IDX_EXT_POLL: x_byte = ext_poll_reg;
				IDX_CHECKSUM: x_byte = 8'h00 - x_sum_reg; // R23
				default: x_byte = 8'h00;
			endcase
		end
	end

	// Data register stream
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			x_idx_reg <= 10'h000;
			x_ent_reg <= 5'h00;
			x_byte_reg <= 4'h0;
			x_sum_reg <= 8'h00;
			data_reg <= 8'h00;
		end else if (ce) begin
			if (state_reg == ST_EXEC) begin
				x_idx_reg <= 10'h000;
				x_ent_reg <= 5'h00;
				x_byte_reg <= 4'h0;
				x_sum_reg <= 8'h00;
			end else if (state_reg == ST_XFER && data_rd) begin
				data_reg <= x_byte;
				x_sum_reg <= x_sum_reg + x_byte; // R23
				x_idx_reg <= x_idx_reg + 10'h001;
				if (x_idx_reg >= IDX_ATTR_FIRST && x_idx_reg <= IDX_ATTR_LAST) begin
					if (x_byte_reg == 4'(ATTR_BYTES - 1)) begin
						x_byte_reg <= 4'h0;
						x_ent_reg <= x_ent_reg + 5'h01;
					end else begin
						x_byte_reg <= x_byte_reg + 4'h1;
					end
				end
			end
		end
	end

	// Attribute memories: monitoring writes to value bytes gated by enable or self-preserving flag
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int e = 0; e < ATTR_MAX; e++) begin
				thr_mem[e] <= 8'h00;
				for (int b = 0; b < ATTR_BYTES; b++) begin
					live_mem[e][b] <= 8'h00;
					sav_mem[e][b] <= 8'h00;
				end
			end
		end else if (ce) begin
			if (bus.we && bus_attr && (smart_en_reg || b_byte < 4'(ENT_VALUE) ||
				live_mem[b_ent][ENT_FLAGS_LO][FLAG_SELF_PRES]))
				live_mem[b_ent][b_byte] <= bus.wdata[7:0]; // R2 R6 R21
			if (bus.we && bus_thr)
				thr_mem[bus.addr[6:2]] <= bus.wdata[7:0];
			if (save_now)
				sav_mem <= live_mem; // R8 R9
		end
	end

	// Register file
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			off_stat_reg <= 8'h00;
			selftest_reg <= 8'h00;
			off_time_reg <= 16'h0000;
			off_cap_reg <= 8'h00;
			smart_cap_reg <= 16'h0000;
			errlog_reg <= 1'b0;
			checkpoint_reg <= 8'h00;
			short_poll_reg <= 8'h00;
			ext_poll_reg <= 8'h00;
			rdata_reg <= 32'h0000_0000;
		end else if (ce) begin
			if (bus.we) begin
				case (bus.addr)
					REG_OFF_STAT: off_stat_reg <= bus.wdata[7:0];
					REG_SELFTEST: selftest_reg <= bus.wdata[7:0];
					REG_OFF_TIME: off_time_reg <= bus.wdata[15:0];
					REG_CAPS: begin
						smart_cap_reg <= bus.wdata[15:0];
						off_cap_reg <= bus.wdata[23:16];
						errlog_reg <= bus.wdata[24];
					end
					REG_POLL: begin
						short_poll_reg <= bus.wdata[7:0];
						ext_poll_reg <= bus.wdata[15:8];
						checkpoint_reg <= bus.wdata[23:16];
					end
					default: ;
				endcase
			end
			rdata_reg <= 32'h0000_0000;
			if (bus.re) begin
				if (bus_attr)
					rdata_reg <= {24'h000000, live_mem[b_ent][b_byte]};
				else if (bus_thr)
					rdata_reg <= {24'h000000, thr_mem[bus.addr[6:2]]};
				else begin
					case (bus.addr)
						REG_STATUS: rdata_reg <= {22'h000000, state_reg, tf_reg.err, tf_reg.intrq,
							tf_reg.drq, tf_reg.bsy, smart_en_reg};
						REG_OFF_STAT: rdata_reg <= {24'h000000, off_stat_reg};
						REG_SELFTEST: rdata_reg <= {24'h000000, selftest_reg};
						REG_OFF_TIME: rdata_reg <= {16'h0000, off_time_reg};
						REG_CAPS: rdata_reg <= {7'h00, errlog_reg, off_cap_reg, smart_cap_reg};
						REG_POLL: rdata_reg <= {8'h00, checkpoint_reg, ext_poll_reg, short_poll_reg};
						default: rdata_reg <= 32'h0000_0000;
					endcase
				end
			end
		end
	end

	assign tf = tf_reg;
	assign data_out = data_reg;
	assign rdata = rdata_reg;
	assign nv_wr = nv_wr_reg;
	assign nv_wr_val = nv_val_reg;
	assign smart_on = smart_en_reg;
endmodule

/* test/seh_checker_assertions.sv */
// Port-level assertions for the SMART handler, attached by bind.
// Assumes ce stays high while a command is in flight and commands follow the hand-over timing.
module seh_checker
	import seh_pkg::*;
#(
	parameter int unsigned ATTR_NUM = 30
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic ce,
	input wire seh_pkg::seh_cmd_t cmd,
	input wire logic data_rd,
	input wire seh_pkg::seh_tf_t tf,
	input wire logic nv_state,
	input wire logic nv_wr,
	input wire logic nv_wr_val,
	input wire logic smart_on
);
	import seh_pkg::*;
	localparam int RS_DONE = ATTR_NUM + 3;
	logic [1:0] ld_reg;
	logic [9:0] rd_reg;
	logic take;
	logic [7:0] f;
	// Commands before the stored enable level is loaded are ignored
	assign take = ce && cmd.valid && !tf.bsy && !tf.drq && ld_reg == 2'h3;
	assign f = cmd.feature;
	always_ff @(posedge clk) begin
		if (sys_rst)
			ld_reg <= 2'h0;
		else if (ce && ld_reg != 2'h3)
			ld_reg <= ld_reg + 2'h1;
	end
	always_ff @(posedge clk) begin
		if (sys_rst || take)
			rd_reg <= 10'h000;
		else if (ce && data_rd && tf.drq)
			rd_reg <= rd_reg + 10'h001;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	busy_on_take_a: assert property (take |=> tf.bsy)
		else $error("busy missing after command");
	enable_store_a: assert property (take && f == SUB_ENABLE |-> ##2 smart_on && nv_wr && nv_wr_val)
		else $error("enable not stored");
	enable_done_a: assert property (take && f == SUB_ENABLE |-> ##3 !tf.bsy && tf.intrq && !tf.abrt)
		else $error("enable not completed");
	disable_done_a: assert property (take && f == SUB_DISABLE && smart_on |-> ##3 !smart_on && !tf.bsy && tf.intrq)
		else $error("disable not completed");
	off_abort_a: assert property (take && !smart_on && f != SUB_ENABLE |-> ##3 tf.err && tf.abrt && tf.intrq)
		else $error("command not aborted while off");
	status_busy_a: assert property (take && smart_on && f == SUB_RETURN_STATUS |=> tf.bsy [*8])
		else $error("busy dropped during status");
	status_sig_a: assert property (take && smart_on && f == SUB_RETURN_STATUS |-> ##RS_DONE !tf.bsy && tf.intrq
		&& ({tf.lba_mid, tf.lba_high} == {SIG_GOOD_MID, SIG_GOOD_HIGH}
		|| {tf.lba_mid, tf.lba_high} == {SIG_FAIL_MID, SIG_FAIL_HIGH}))
		else $error("status signature wrong");
	xfer_start_a: assert property (take && smart_on && f == SUB_READ_VALUES |-> ##2 tf.drq && !tf.bsy && tf.intrq)
		else $error("transfer not started");
	xfer_hold_a: assert property (tf.drq && !(data_rd && rd_reg == 10'h1ff) |=> tf.drq)
		else $error("transfer ended early");
	xfer_end_a: assert property (tf.drq && data_rd && rd_reg == 10'h1ff |=> !tf.drq)
		else $error("transfer did not end");
	nv_load_a: assert property (ld_reg == 2'h2 |=> smart_on == nv_state)
		else $error("stored state not restored");
	cover property (take && f == SUB_ENABLE);
	cover property (take && f == SUB_RETURN_STATUS);
	cover property (tf.drq && data_rd && rd_reg == 10'h1ff);
endmodule

bind seh_smart_handler seh_checker #(.ATTR_NUM(ATTR_NUM)) i_seh_checker (.clk(clk), .sys_rst(sys_rst), .ce(ce),
	.cmd(cmd), .data_rd(data_rd), .tf(tf), .nv_state(nv_state), .nv_wr(nv_wr), .nv_wr_val(nv_wr_val),
	.smart_on(smart_on));

/* test/seh_host_model.sv */
// Host model: issues SMART subcommands and drains the data register.
// Assumes the handler's task-file outputs share clk; drives at rising edges.
module seh_host_model
	import seh_pkg::*;
(
	input wire logic clk,
	input wire seh_pkg::seh_tf_t tf,
	input wire logic [7:0] data_out,
	output seh_pkg::seh_cmd_t cmd,
	output logic intrq_ack,
	output logic data_rd
);
	import seh_pkg::*;
	logic [7:0] blk [512];
	initial begin
		cmd = '0;
		intrq_ack = 1'b0;
		data_rd = 1'b0;
	end
	// One command at a time: wait idle, pulse, wait completion, acknowledge
	task automatic issue(input logic [7:0] code);
		// No limit here: a hang runs into the bench watchdog, which fails the run
		while (tf.bsy || tf.drq) begin
			@(posedge clk);
			#1;
		end
		@(posedge clk) cmd <= '{1'b1, code, 8'h00};
		@(posedge clk) cmd.valid <= 1'b0;
		while (!tf.intrq) begin
			@(posedge clk);
			#1;
		end
		@(posedge clk) intrq_ack <= 1'b1;
		@(posedge clk) intrq_ack <= 1'b0;
	endtask
	// Whole structure in one pass, one byte per cycle
	task automatic read_block();
		@(posedge clk) data_rd <= 1'b1;
		for (int i = 0; i < 512; i++) begin
			@(posedge clk);
			if (i == 511)
				data_rd <= 1'b0;
			#1 blk[i] = data_out;
		end
	endtask
endmodule

/* test/testbench.sv */
// Self-checking bench for the SMART handler: register tasks plus host model calls.
// Assumes one 40 MHz clock and a synchronous active-high reset.
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin fail_count++; \
	$display("MISMATCH %s expected %0h seen %0h", nm, ex, got); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import seh_pkg::*;
	localparam logic [15:0] SIG_F = {SIG_FAIL_MID, SIG_FAIL_HIGH};
	localparam logic [15:0] SIG_G = {SIG_GOOD_MID, SIG_GOOD_HIGH};
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic ce = 1'b1;
	logic nv_state = 1'b0;
	logic pwr_save_evt = 1'b0;
	seh_bus_t bus = '0;
	seh_cmd_t cmd;
	seh_tf_t tf;
	logic intrq_ack, data_rd, nv_wr, nv_wr_val, smart_on;
	logic [7:0] data_out, sum, rsv;
	logic [7:0] b [512];
	logic [31:0] rdata, v;
	logic [7:0] codes [4] = '{SUB_DISABLE, SUB_RETURN_STATUS, SUB_READ_VALUES, SUB_SAVE_VALUES};
	logic rs_flag [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
	logic [31:0] rs_val [4] = '{32'h10, 32'h10, 32'h20, 32'h21};
	logic [15:0] rs_exp [4] = '{SIG_F, SIG_G, SIG_F, SIG_G};
	int fail_count = 0;
	int check_count = 0;
	always #12.5 clk = ~clk;
	seh_host_model i_seh_host_model (.clk(clk), .tf(tf), .data_out(data_out), .cmd(cmd), .intrq_ack(intrq_ack),
		.data_rd(data_rd));
	seh_smart_handler i_seh_smart_handler (.clk(clk), .sys_rst(sys_rst), .ce(ce), .cmd(cmd), .intrq_ack(intrq_ack),
		.data_rd(data_rd), .data_out(data_out), .tf(tf), .bus(bus), .rdata(rdata), .nv_state(nv_state),
		.nv_wr(nv_wr), .nv_wr_val(nv_wr_val), .pwr_save_evt(pwr_save_evt), .smart_on(smart_on));
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clk) bus.we <= 1'b0;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a);
		@(posedge clk) bus <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge clk) bus.re <= 1'b0;
		#1 v = rdata;
	endtask
	// Nonvolatile store behind the pins: keeps the last written enable level across resets
	always @(posedge clk) begin
		if (nv_wr)
			nv_state <= nv_wr_val;
	end
	// First command only after the stored state has been loaded
	task automatic do_reset();
		@(posedge clk) sys_rst <= 1'b1;
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (5) @(posedge clk);
		#1;
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		do_reset();
		`CHK("smart_on", 1'b0, smart_on)
		foreach (codes[i]) begin
			i_seh_host_model.issue(codes[i]);
			#1 `CHK("abort", 2'h3, {tf.err, tf.abrt})
		end
		$display("test off_abort done");
		wr(13'h0800, 32'h01);
		wr(13'h0804, 32'h21);
		wr(13'h080c, 32'h10);
		rd(13'h080c);
		`CHK("self value", 32'h10, v)
		wr(13'h0804, 32'h01);
		wr(13'h080c, 32'h77);
		rd(13'h080c);
		`CHK("frozen value", 32'h10, v)
		@(posedge clk) pwr_save_evt <= 1'b1;
		repeat (4) @(posedge clk);
		pwr_save_evt <= 1'b0;
		wr(13'h0400, 32'h20);
		rd(13'h0100);
		`CHK("unmapped", 32'h0, v)
		$display("test off_values done");
		i_seh_host_model.issue(SUB_ENABLE);
		#1 `CHK("enabled", 1'b1, smart_on)
		rd(REG_STATUS);
		`CHK("status on", 1'b1, v[0])
		i_seh_host_model.issue(SUB_ENABLE);
		rd(13'h080c);
		`CHK("value kept", 32'h10, v)
		i_seh_host_model.issue(SUB_SAVE_VALUES);
		#1 `CHK("save accepted", 2'h0, {tf.err, tf.abrt})
		$display("test enable done");
		for (int i = 0; i < 4; i++) begin
			wr(13'h0804, {31'h0, rs_flag[i]});
			wr(13'h080c, rs_val[i]);
			i_seh_host_model.issue(SUB_RETURN_STATUS);
			#1 `CHK("signature", rs_exp[i], {tf.lba_mid, tf.lba_high})
		end
		$display("test status done");
		// A write while the clock enable is low must leave the registers untouched
		@(posedge clk) ce <= 1'b0;
		wr(REG_POLL, 32'h0000_00ff);
		@(posedge clk) ce <= 1'b1;
		rd(REG_POLL);
		`CHK("frozen poll", 32'h0, v)
		wr(REG_POLL, 32'h0007_0502);
		wr(REG_CAPS, 32'h015b_0003);
		rd(REG_CAPS);
		`CHK("caps", 32'h015b_0003, v)
		$display("test clock_enable done");
		i_seh_host_model.issue(SUB_READ_VALUES);
		#1 `CHK("drq", 1'b1, tf.drq)
		i_seh_host_model.read_block();
		@(posedge clk);
		#1 `CHK("drq end", 1'b0, tf.drq)
		b = i_seh_host_model.blk;
		sum = 8'h00;
		rsv = 8'h00;
		for (int i = 0; i < 512; i++) begin
			sum += b[i];
			if (i >= 374 && i <= 510)
				rsv |= b[i];
		end
		`CHK("revision", STRUCT_REV, {b[1], b[0]})
		`CHK("entry id", 8'h01, b[2])
		`CHK("entry flags", 8'h01, b[3])
		`CHK("entry value", 8'h21, b[5])
		`CHK("checksum", 8'h00, sum)
		`CHK("reserved", 8'h00, rsv)
		`CHK("offline cap", 8'h5b, b[367])
		`CHK("smart cap", 16'h0003, {b[369], b[368]})
		`CHK("errlog", 8'h01, b[370])
		`CHK("checkpoint", 8'h07, b[371])
		`CHK("poll times", 16'h0502, {b[373], b[372]})
		$display("test read_values done");
		i_seh_host_model.issue(SUB_DISABLE);
		#1 `CHK("disabled", 1'b0, smart_on)
		`CHK("stored off", 1'b0, nv_state)
		rd(13'h080c);
		`CHK("retained", 32'h21, v)
		do_reset();
		`CHK("restored off", 1'b0, smart_on)
		i_seh_host_model.issue(SUB_ENABLE);
		#1 `CHK("stored on", 1'b1, nv_state)
		do_reset();
		`CHK("restored on", 1'b1, smart_on)
		$display("test disable done");
		complete_run();
	end
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		complete_run();
	end
endmodule
